/* telemetry_params.svh */
/*
 * Holds the offsets, field positions and steps of the telemetry bank.
 * Assumes it is included once by each file that needs it, by its bare name.
 */
`ifndef TELEMETRY_PARAMS_SVH
`define TELEMETRY_PARAMS_SVH

// ****************************************************************
// Host access locations
// ****************************************************************
`define POINTER_LOCATION 8'h80

// ****************************************************************
// Read-back sub-addresses
// ****************************************************************
`define OFS_REVISION 8'h00
`define OFS_VOLTAGE_SETPOINT 8'h02
`define OFS_UNDERVOLTAGE 8'h04
`define OFS_OVERVOLTAGE 8'h06
`define OFS_CONTROL_FLAGS 8'h08
`define OFS_CURRENT_POWER 8'h0a
`define OFS_FAULT_CONFIG 8'h0c
`define OFS_MEASURED_CURRENT 8'h0e
`define OFS_MEASURED_VOLTAGE 8'h12

// ****************************************************************
// Field positions
// ****************************************************************
`define HIGH_PARITY_BIT 15
`define LOW_PARITY_BIT 7
`define FLAG_BUS_SWITCH 14
`define FLAG_BLEEDER 13
`define FLAG_TURN_OFF 12
`define FLAG_FAST_VI 11
`define FLAG_VOLTAGE_ONLY 10
`define FLAG_OTP_HYST 9

// ****************************************************************
// Measured voltage resolution, in millivolts
// ****************************************************************
`define VRANGE_MID_START_MV 15'h1c20
`define VRANGE_HIGH_START_MV 15'h2710
`define VSTEP_LOW_MV 15'h0014
`define VSTEP_MID_MV 15'h0032
`define VSTEP_HIGH_MV 15'h0064
`define VCODE_UNIT_MV 15'h000a

`endif

/* telemetry_pkg.sv */
/*
 * Holds the types shared by the telemetry read-back bank.
 * Assumes the constants header is available for inclusion.
 */
package telemetry_pkg;

  typedef logic [7:0] subaddr_t;
  typedef logic [15:0] word_t;
  typedef logic [14:0] millivolt_t;

  typedef enum logic [2:0] {
    RANGE_LOW = 3'b001,
    RANGE_MID = 3'b010,
    RANGE_HIGH = 3'b100
  } vrange_t;

endpackage : telemetry_pkg

/* odd_parity_word.sv */
/*
 * Packs a value into a read-back word with an odd parity bit per byte.
 * Assumes HI_W is between 1 and 6 and the value is held stable by its source.
 */
`timescale 1ns/100ps
`include "telemetry_params.svh"

module odd_parity_word #(
  parameter int HI_W = 1
)(
  // Value, high part above the low seven bits
  input wire logic [HI_W+6:0] value,
  // Packed word
  output telemetry_pkg::word_t word
);
  import telemetry_pkg::*;

  logic [6:0] highByte;
  logic [6:0] lowByte;

  assign highByte = {{(7-HI_W){1'b0}}, value[HI_W+6:7]};
  assign lowByte = value[6:0];

  // Each parity bit makes its byte, parity included, odd.
  always_comb
  begin
    word = {1'b0, highByte, 1'b0, lowByte};
    word[`HIGH_PARITY_BIT] = ~^highByte;
    word[`LOW_PARITY_BIT] = ~^lowByte;
  end

endmodule : odd_parity_word

/* voltage_report_encoder.sv */
/*
 * Turns a measured output voltage into its 12-bit report code.
 * Assumes the measurement arrives in millivolts and stays below 20.48 V.
 */
`timescale 1ns/100ps
`include "telemetry_params.svh"

module voltage_report_encoder (
  // Measurement
  input wire telemetry_pkg::millivolt_t millivolts,
  // Report code in 10 mV units, quantised to the range step
  output logic [11:0] code
);
  import telemetry_pkg::*;

  vrange_t range;
  millivolt_t step;
  millivolt_t quantised;

  always_comb
  begin
    if (millivolts < `VRANGE_MID_START_MV)
      range = RANGE_LOW;
    else if (millivolts < `VRANGE_HIGH_START_MV)
      range = RANGE_MID;
    else
      range = RANGE_HIGH;
  end

  // The step coarsens as the voltage rises.
  always_comb
  begin
    unique case (range)
      RANGE_LOW: step = `VSTEP_LOW_MV;
      RANGE_MID: step = `VSTEP_MID_MV;
      RANGE_HIGH: step = `VSTEP_HIGH_MV;
      default: step = `VSTEP_HIGH_MV;
    endcase
  end

  // Truncation to the step keeps the code on the range's grid.
  assign quantised = millivolt_t'(millivolts - (millivolts % step));
  assign code = 12'(quantised / `VCODE_UNIT_MV);

endmodule : voltage_report_encoder

/* telemetry_readback_regs.sv */
/*
 * Read-only telemetry bank: the host writes a sub-address to the pointer
 * location and then reads the selected word back from the same location.
 * Assumes the serial command layer delivers decoded one-cycle strobes,
 * and that settings and measurements come from core_clk logic.
 */
// How it works
// - Sub-address 0x00, reached via 0x80, returns the 16-bit revision value.
// - Word 0x02 returns the voltage set-point in bits 12:8 and 6:0.
// - Parity-protected words carry high-byte parity bit 15, low-byte bit 7.
// - Undervoltage threshold word holds value in bit 8 and bits 6:0.
// - Word 0x06 returns the overvoltage threshold laid out like word 0x04.
// - Word 0x08 returns control flags in bits 14 to 9 and 3:0.
// - Word 0x0A returns current set-point high byte, power knee low byte.
// - Fault configuration word packs eight two-bit response and timer fields.
// - Measured current word holds value in bit 8 and bits 6:0.
// - Measured voltage is 12 bits in 11:0, with zeros in 15:12.
// - Every parity bit gives its byte odd parity.
`timescale 1ns/100ps
`include "telemetry_params.svh"

module telemetry_readback_regs #(
  parameter logic [15:0] REVISION = 16'h0001 // Arbitrary value.
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Host command strobes
  input wire logic cmdWrite,
  input wire telemetry_pkg::subaddr_t cmdAddr,
  input wire logic [7:0] cmdLowByte,
  input wire logic readReq,
  input wire telemetry_pkg::subaddr_t readAddr,
  // Host answer
  output telemetry_pkg::word_t readData,
  output logic readValid,
  // Programmed set-points
  input wire logic [11:0] voltage_setpoint,
  input wire logic [7:0] undervoltage_threshold,
  input wire logic [7:0] overvoltage_threshold,
  input wire logic [7:0] current_setpoint,
  input wire logic [7:0] power_knee_threshold,
  // Control flags
  input wire logic bus_switch_enable,
  input wire logic bleeder_enable,
  input wire logic supply_turn_off,
  input wire logic fast_vi_commands,
  input wire logic voltage_only_mode,
  input wire logic overtemp_hysteresis,
  input wire logic [3:0] cable_drop_comp,
  // Fault configuration
  input wire logic [1:0] overvoltage_response,
  input wire logic [1:0] undervoltage_response,
  input wire logic [1:0] output_short_response,
  input wire logic [1:0] sense_pin_short_response,
  input wire logic [1:0] undervoltage_timeout,
  input wire logic [1:0] watchdog_timeout,
  input wire logic [1:0] voltage_mode_fault_response,
  input wire logic [1:0] voltage_mode_fault_timer,
  // Measurements
  input wire logic [7:0] measured_current,
  input wire telemetry_pkg::millivolt_t measured_millivolts
);
  import telemetry_pkg::*;

  // ****************************************************************
  // Read pointer
  // ****************************************************************
  subaddr_t pointer_q;

  // Only a write to the pointer location moves the pointer.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      pointer_q <= 8'h00;
    else if (cmdWrite && cmdAddr == `POINTER_LOCATION)
      pointer_q <= cmdLowByte;
  end

  // ****************************************************************
  // Word assembly
  // ****************************************************************
  word_t setpointWord;
  word_t underWord;
  word_t overWord;
  word_t currentWord;
  word_t flagsWord;
  word_t faultWord;
  logic [11:0] voltageCode;

  odd_parity_word #(.HI_W(5)) u_setpoint_word (
    .value(voltage_setpoint),
    .word(setpointWord)
  );

  odd_parity_word #(.HI_W(1)) u_under_word (
    .value(undervoltage_threshold),
    .word(underWord)
  );

  odd_parity_word #(.HI_W(1)) u_over_word (
    .value(overvoltage_threshold),
    .word(overWord)
  );

  odd_parity_word #(.HI_W(1)) u_current_word (
    .value(measured_current),
    .word(currentWord)
  );

  voltage_report_encoder u_voltage_encoder (
    .millivolts(measured_millivolts),
    .code(voltageCode)
  );

  always_comb
  begin
    flagsWord = 16'h0000;
    flagsWord[`FLAG_BUS_SWITCH] = bus_switch_enable;
    flagsWord[`FLAG_BLEEDER] = bleeder_enable;
    flagsWord[`FLAG_TURN_OFF] = supply_turn_off;
    flagsWord[`FLAG_FAST_VI] = fast_vi_commands;
    flagsWord[`FLAG_VOLTAGE_ONLY] = voltage_only_mode;
    flagsWord[`FLAG_OTP_HYST] = overtemp_hysteresis;
    flagsWord[3:0] = cable_drop_comp;
  end

  assign faultWord = {overvoltage_response, undervoltage_response,
                      output_short_response, sense_pin_short_response,
                      undervoltage_timeout, watchdog_timeout,
                      voltage_mode_fault_response,
                      voltage_mode_fault_timer};

  // ****************************************************************
  // Read-back selection
  // ****************************************************************
  word_t selected;

  always_comb
  begin
    case (pointer_q)
      `OFS_REVISION: selected = REVISION;
      `OFS_VOLTAGE_SETPOINT: selected = setpointWord;
      `OFS_UNDERVOLTAGE: selected = underWord;
      `OFS_OVERVOLTAGE: selected = overWord;
      `OFS_CONTROL_FLAGS: selected = flagsWord;
      `OFS_CURRENT_POWER: selected = {current_setpoint,
                                      power_knee_threshold};
      `OFS_FAULT_CONFIG: selected = faultWord;
      `OFS_MEASURED_CURRENT: selected = currentWord;
      `OFS_MEASURED_VOLTAGE: selected = {4'h0, voltageCode};
      default: selected = 16'h0000;
    endcase
  end

  // ****************************************************************
  // Host answer
  // ****************************************************************
  // A read samples the chosen word, or zero when readAddr is not the pointer location; nothing else changes.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      readData <= 16'h0000;
    else if (readReq)
      readData <= (readAddr == `POINTER_LOCATION) ? selected : 16'h0000;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      readValid <= 1'b0;
    else
      readValid <= readReq;
  end

endmodule : telemetry_readback_regs

/* telemetry_readback_props.sv */
/* Port checker for the telemetry read-back bank.
   Assumes it is bound to telemetry_readback_regs. */
`timescale 1ns/100ps
module telemetry_readback_props
  import telemetry_pkg::*;
#(
  parameter logic [15:0] REVISION = 16'h0001
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Host side
  input wire logic cmdWrite,
  input wire telemetry_pkg::subaddr_t cmdAddr,
  input wire logic [7:0] cmdLowByte,
  input wire logic readReq,
  input wire telemetry_pkg::subaddr_t readAddr,
  input wire telemetry_pkg::word_t readData,
  input wire logic readValid,
  // Set-points
  input wire logic [7:0] current_setpoint,
  input wire logic [7:0] power_knee_threshold
);
  // ****************************************************************
  // Selected word tracking
  // ****************************************************************
  // A foreign read location answers as selection 0xff.
  subaddr_t pointer_q;
  subaddr_t sel_q;
  always_ff @(posedge core_clk or posedge reset)
    if (reset) pointer_q <= 8'h00;
    else if (cmdWrite && cmdAddr == 8'h80) pointer_q <= cmdLowByte;
  always_ff @(posedge core_clk or posedge reset)
    if (reset) sel_q <= 8'h00;
    else if (readReq) sel_q <= (readAddr == 8'h80) ? pointer_q : 8'hff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_answer; readReq |=> readValid; endproperty
  a_answer: assert property (p_answer)
    else $error("no answer after read");
  property p_pulse; readValid |-> $past(readReq); endproperty
  a_pulse: assert property (p_pulse)
    else $error("answer without read");
  property p_hold; !readReq |=> $stable(readData); endproperty
  a_hold: assert property (p_hold)
    else $error("read word changed without read");
  property p_rev; readValid && sel_q == 8'h00 |-> readData == REVISION;
  endproperty
  a_rev: assert property (p_rev)
    else $error("bad revision word");
  property p_parity;
    readValid && sel_q inside {8'h02, 8'h04, 8'h06, 8'h0e}
      |-> ^readData[15:8] && ^readData[7:0];
  endproperty
  a_parity: assert property (p_parity)
    else $error("even byte parity");
  property p_gap;
    readValid && sel_q inside {8'h04, 8'h06, 8'h0e}
      |-> readData[14:9] == 6'h00;
  endproperty
  a_gap: assert property (p_gap)
    else $error("unused bits set");
  property p_setpt; readValid && sel_q == 8'h02 |-> readData[14:13] == 2'h0;
  endproperty
  a_setpt: assert property (p_setpt)
    else $error("set-point gap bits set");
  property p_flags;
    readValid && sel_q == 8'h08 |-> !readData[15] && readData[8:4] == 5'h00;
  endproperty
  a_flags: assert property (p_flags)
    else $error("flag word spare bits set");
  property p_pair;
    readValid && sel_q == 8'h0a
      |-> readData == {$past(current_setpoint), $past(power_knee_threshold)};
  endproperty
  a_pair: assert property (p_pair)
    else $error("current and knee word wrong");
  property p_vtop; readValid && sel_q == 8'h12 |-> readData[15:12] == 4'h0;
  endproperty
  a_vtop: assert property (p_vtop)
    else $error("voltage top bits set");
  c_volt: cover property (readValid && sel_q == 8'h12);
  c_foreign: cover property (readValid && sel_q == 8'hff);
  c_back: cover property (cmdWrite ##1 readReq);
endmodule : telemetry_readback_props

bind telemetry_readback_regs telemetry_readback_props #(.REVISION(REVISION))
  telemetry_readback_props_inst (.*);

/* host_model.sv */
/* Host model: loads the read pointer, then reads a word back.
   Assumes the bank answers one cycle after the read strobe. */
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic core_clk,
  // Strobes
  output logic cmdWrite,
  output telemetry_pkg::subaddr_t cmdAddr,
  output logic [7:0] cmdLowByte,
  output logic readReq,
  output telemetry_pkg::subaddr_t readAddr,
  // Answer
  input wire telemetry_pkg::word_t readData,
  input wire logic readValid
);
  import telemetry_pkg::*;
  initial
  begin
    {cmdWrite, readReq, cmdAddr, cmdLowByte, readAddr} = '0;
  end
  // Released lines are inverted so stale values never look valid.
  task fetch(input subaddr_t sub, input subaddr_t loc, output word_t w);
    @(negedge core_clk);
    cmdWrite = 1'b1;
    cmdAddr = 8'h80;
    cmdLowByte = sub;
    @(negedge core_clk);
    cmdWrite = 1'b0;
    cmdAddr = ~cmdAddr;
    cmdLowByte = ~cmdLowByte;
    readReq = 1'b1;
    readAddr = loc;
    @(negedge core_clk);
    readReq = 1'b0;
    readAddr = ~readAddr;
    w = (readValid === 1'b1) ? readData : 16'hxxxx;
  endtask : fetch
endmodule : host_model

/* tb_top.sv */
/* Self-checking bench for the telemetry read-back bank.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/100ps
module tb_top;
  import telemetry_pkg::*;
  localparam logic [15:0] REV = 16'h3c5a; // Arbitrary value.
  localparam subaddr_t SUBS [10] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08,
    8'h0a, 8'h0c, 8'h0e, 8'h12, 8'h10};
  localparam int MV [6] = '{3000, 7199, 7200, 9999, 10000, 20479};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic cmdWrite, readReq, readValid;
  subaddr_t cmdAddr, readAddr;
  logic [7:0] cmdLowByte, undervoltage_threshold, overvoltage_threshold;
  logic [7:0] current_setpoint, power_knee_threshold, measured_current;
  word_t readData, w;
  logic [11:0] voltage_setpoint;
  logic bus_switch_enable, bleeder_enable, supply_turn_off;
  logic fast_vi_commands, voltage_only_mode, overtemp_hysteresis;
  logic [3:0] cable_drop_comp;
  logic [1:0] overvoltage_response, undervoltage_response;
  logic [1:0] output_short_response, sense_pin_short_response;
  logic [1:0] undervoltage_timeout, watchdog_timeout;
  logic [1:0] voltage_mode_fault_response, voltage_mode_fault_timer;
  millivolt_t measured_millivolts = 15'h0bb8;
  int n_mismatch = 0;
  int comparisons = 0;
  always #20 core_clk = ~core_clk;
  telemetry_readback_regs #(.REVISION(REV)) telemetry_readback_regs_inst (.*);
  host_model host_model_inst (.*);
  // ****************************************************************
  // Stimulus and expectations
  // ****************************************************************
  task drive(input logic [15:0] p);
    {voltage_setpoint, undervoltage_threshold} = {p[11:0], p[15:8]};
    {overvoltage_threshold, current_setpoint} = {p[7:0], ~p[15:8]};
    {power_knee_threshold, measured_current} = {p[9:2], p[13:6]};
    {bus_switch_enable, bleeder_enable, supply_turn_off, fast_vi_commands,
      voltage_only_mode, overtemp_hysteresis, cable_drop_comp} = p[9:0];
    {overvoltage_response, undervoltage_response, output_short_response,
      sense_pin_short_response, undervoltage_timeout, watchdog_timeout,
      voltage_mode_fault_response, voltage_mode_fault_timer} = p;
  endtask : drive
  function word_t pw(logic [7:0] v);
    return {~v[7], 6'h00, v[7], ~^v[6:0], v[6:0]};
  endfunction : pw
  function word_t expect_word(subaddr_t s);
    int st;
    st = (measured_millivolts < 7200) ? 20 :
      (measured_millivolts < 10000) ? 50 : 100;
    case (s)
      8'h00: return REV;
      8'h02: return {~^voltage_setpoint[11:7], 2'h0, voltage_setpoint[11:7],
        ~^voltage_setpoint[6:0], voltage_setpoint[6:0]};
      8'h04: return pw(undervoltage_threshold);
      8'h06: return pw(overvoltage_threshold);
      8'h08: return {1'b0, bus_switch_enable, bleeder_enable, supply_turn_off,
        fast_vi_commands, voltage_only_mode, overtemp_hysteresis, 5'h00,
        cable_drop_comp};
      8'h0a: return {current_setpoint, power_knee_threshold};
      8'h0c: return {overvoltage_response, undervoltage_response,
        output_short_response, sense_pin_short_response, undervoltage_timeout,
        watchdog_timeout, voltage_mode_fault_response,
        voltage_mode_fault_timer};
      8'h0e: return pw(measured_current);
      8'h12: return {4'h0, 12'(measured_millivolts / st * st / 10)};
      default: return 16'h0000;
    endcase
  endfunction : expect_word
  task check(input word_t seen, input word_t exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task read_chk(input subaddr_t s);
    host_model_inst.fetch(s, 8'h80, w);
    check(w, expect_word(s));
  endtask : read_chk
  task finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    drive(16'ha5c3);
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    check({15'h0000, readValid}, 16'h0000);
    check(readData, 16'h0000);
    reset = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      drive(k ? 16'h5a3c : 16'ha5c3);
      foreach (SUBS[i])
      begin
        read_chk(SUBS[i]);
        read_chk(SUBS[i]);
      end
    end
    host_model_inst.fetch(8'h02, 8'h81, w);
    check(w, 16'h0000);
    foreach (MV[i])
    begin
      measured_millivolts = 15'(MV[i]);
      read_chk(8'h12);
    end
    finish_test();
  end
  initial
  begin
    #40000;
    n_mismatch++;
    finish_test();
  end
endmodule : tb_top
